// *** phyirq_top.sv ***
// Added by the designer: the APB register port.
`timescale 1ns/10ps
// How it works
// [R1] clear bit 7 drops autoneg alarm, zeroes counter
// [R2] clear bit 3 drops link alarm, zeroes counters
// [R3] low clear bits drop their matching flags
// [R4] clear bits read zero; zero writes change nothing
// [R5] high clear bits drop flags; 7,2,1 inert
// [R6] high clear bit 3 drops error alarm
// [R7] pin control: enable with leds, polarity select
// [R8] autoneg count limit, read-write, resets 0xff
// [R9] link count limit, read-write, resets 0xff
// [R10] error count limit, read-write, resets 0xff
// [R11] flag reaches pin only when enabled
// [R12] count alarm sets at limit, stays till cleared
module phyirq_top
(
    // apb clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [17:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // transceiver core events and led enable
    input  wire phyirq_pkg::phyirq_evt_type  evt,
    input  wire logic                        led_enable,
    // interrupt pin level
    output logic                             irq_pin
);

    // register state
    logic [7:0]   en_low_ff;        // per-source enables, low
    logic [7:0]   en_high_ff;       // per-source enables, high
    logic [7:0]   ctl_ff;           // pin control
    logic [7:0]   an_limit_ff;      // autoneg count limit
    logic [7:0]   link_limit_ff;    // link count limit
    logic [7:0]   err_limit_ff;     // error count limit
    logic [15:0]  flags_ff;         // latched flags
    logic [7:0]   an_cnt_ff;        // autoneg event counter
    logic [7:0]   l10_cnt_ff;       // 10 mb/s link counter
    logic [7:0]   l100_cnt_ff;      // 100 mb/s link counter
    logic [7:0]   l1000_cnt_ff;     // 1000 mb/s link counter
    logic [7:0]   err_cnt_ff;       // error event counter
    logic [31:0]  prdata_ff;        // read data
    logic         pready_ff;        // access-phase ready
    logic         pslverr_ff;       // unmapped address
    logic         irq_pin_ff;       // pin level

    // bus decode
    logic [15:0]  idx;              // word index
    logic         wr_en;            // write commits this edge
    logic         lo_wr;            // low clear write
    logic         hi_wr;            // high clear write
    logic [15:0]  clr_vec;          // flag clear strobes
    logic [15:0]  set_vec;          // flag set strobes
    logic         an_clr;           // autoneg counter reset
    logic         link_clr;         // link counters reset
    logic [7:0]   nxt_an_cnt;
    logic [7:0]   nxt_l10_cnt;
    logic [7:0]   nxt_l100_cnt;
    logic [7:0]   nxt_l1000_cnt;
    logic [7:0]   nxt_err_cnt;
    logic         an_hit;           // autoneg count reached limit
    logic         link_hit;         // any link count reached limit
    logic         err_hit;          // error count reached limit
    logic         irq_active;       // pin asserted, before polarity
    logic [31:0]  nxt_prdata;
    logic         nxt_pslverr;

    // saturating counter step, reset wins over count
    function automatic logic [7:0] cnt_step(input logic [7:0] cnt, input logic inc, input logic clr);
        logic [7:0] res;
        res = cnt;
        if (clr)
        begin
            res = 8'h00;
        end
        else if (inc && (cnt != 8'hff))
        begin
            res = cnt + 8'h01;
        end
        return res;
    endfunction

    // true when a real increment lands on the limit
    function automatic logic hit(input logic [7:0] cnt, input logic [7:0] nxt, input logic [7:0] lim);
        return (nxt != cnt) && (nxt != 8'h00) && (nxt == lim);
    endfunction

    assign idx   = paddr[17:2];
    assign wr_en = psel && penable && pwrite && pready_ff;
    assign lo_wr = wr_en && (paddr[1:0] == 2'b00) && (idx == phyirq_pkg::IDX_CLR_LOW);
    assign hi_wr = wr_en && (paddr[1:0] == 2'b00) && (idx == phyirq_pkg::IDX_CLR_HIGH);

    // clear strobes: only ones act, nothing is stored
    // [R4] self-clearing strobes
    assign clr_vec = {(hi_wr ? (pwdata[7:0] & phyirq_pkg::CLR_HIGH_MASK) : 8'h00),
                      (lo_wr ? pwdata[7:0] : 8'h00)};
    // [R1] autoneg counter reset
    assign an_clr   = clr_vec[phyirq_pkg::FLG_AN_ALARM];
    // [R2] link counters reset together
    assign link_clr = clr_vec[phyirq_pkg::FLG_LINK_ALARM];

    // counter next values
    assign nxt_an_cnt    = cnt_step(an_cnt_ff, evt.autoneg_done, an_clr);
    assign nxt_l10_cnt   = cnt_step(l10_cnt_ff, evt.link10, link_clr);
    assign nxt_l100_cnt  = cnt_step(l100_cnt_ff, evt.link100, link_clr);
    assign nxt_l1000_cnt = cnt_step(l1000_cnt_ff, evt.link1000, link_clr);
    assign nxt_err_cnt   = cnt_step(err_cnt_ff, evt.error, 1'b0);

    // [R12] alarm raised on reaching limit
    assign an_hit   = hit(an_cnt_ff, nxt_an_cnt, an_limit_ff);
    assign link_hit = hit(l10_cnt_ff, nxt_l10_cnt, link_limit_ff)
                   || hit(l100_cnt_ff, nxt_l100_cnt, link_limit_ff)
                   || hit(l1000_cnt_ff, nxt_l1000_cnt, link_limit_ff);
    assign err_hit  = hit(err_cnt_ff, nxt_err_cnt, err_limit_ff);

    // flag set sources; unused positions stay zero
    always_comb
    begin
        set_vec                             = 16'h0000;
        set_vec[phyirq_pkg::FLG_AN_ALARM]   = an_hit;
        set_vec[phyirq_pkg::FLG_AN_DONE]    = evt.autoneg_done;
        set_vec[phyirq_pkg::FLG_REM_FAULT]  = evt.remote_fault;
        set_vec[phyirq_pkg::FLG_SPEED]      = evt.speed;
        set_vec[phyirq_pkg::FLG_LINK_ALARM] = link_hit;
        set_vec[phyirq_pkg::FLG_LINK]       = evt.link;
        set_vec[phyirq_pkg::FLG_DUPLEX]     = evt.duplex;
        set_vec[phyirq_pkg::FLG_JABBER]     = evt.jabber;
        set_vec[phyirq_pkg::FLG_CONFIG]     = evt.config_chg;
        set_vec[phyirq_pkg::FLG_LOC_RCVR]   = evt.loc_rcvr;
        set_vec[phyirq_pkg::FLG_REM_RCVR]   = evt.rem_rcvr;
        set_vec[phyirq_pkg::FLG_ERR_ALARM]  = err_hit;
        set_vec[phyirq_pkg::FLG_RESET]      = evt.reset_evt;
    end

    // latched flags: set wins over a clear in the same cycle
    // [R3] [R5] [R6] clear matching flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_ff <= 16'h0000;
        end
        else
        begin
            flags_ff <= (flags_ff & ~clr_vec) | set_vec;
        end
    end

    // event counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            an_cnt_ff    <= 8'h00;
            l10_cnt_ff   <= 8'h00;
            l100_cnt_ff  <= 8'h00;
            l1000_cnt_ff <= 8'h00;
            err_cnt_ff   <= 8'h00;
        end
        else
        begin
            an_cnt_ff    <= nxt_an_cnt;
            l10_cnt_ff   <= nxt_l10_cnt;
            l100_cnt_ff  <= nxt_l100_cnt;
            l1000_cnt_ff <= nxt_l1000_cnt;
            err_cnt_ff   <= nxt_err_cnt;
        end
    end

    // software-written registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_low_ff     <= phyirq_pkg::RST_EN;
            en_high_ff    <= phyirq_pkg::RST_EN;
            ctl_ff        <= phyirq_pkg::RST_CTL;
            an_limit_ff   <= phyirq_pkg::RST_LIMIT;
            link_limit_ff <= phyirq_pkg::RST_LIMIT;
            err_limit_ff  <= phyirq_pkg::RST_LIMIT;
        end
        else if (wr_en && (paddr[1:0] == 2'b00))
        begin
            if (idx == phyirq_pkg::IDX_EN_LOW)
            begin
                en_low_ff <= pwdata[7:0];
            end
            else if (idx == phyirq_pkg::IDX_EN_HIGH)
            begin
                en_high_ff <= pwdata[7:0] & phyirq_pkg::EN_HIGH_MASK;
            end
            else if (idx == phyirq_pkg::IDX_PIN_CTL)
            begin
                // [R7] mode and polarity written
                ctl_ff <= pwdata[7:0];
            end
            else if (idx == phyirq_pkg::IDX_AN_LIMIT)
            begin
                // [R8] autoneg limit written
                an_limit_ff <= pwdata[7:0];
            end
            else if (idx == phyirq_pkg::IDX_LINK_LIMIT)
            begin
                // [R9] link limit written
                link_limit_ff <= pwdata[7:0];
            end
            else if (idx == phyirq_pkg::IDX_ERR_LIMIT)
            begin
                // [R10] error limit written
                err_limit_ff <= pwdata[7:0];
            end
        end
    end

    // read mux, evaluated during the setup cycle
    always_comb
    begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (paddr[1:0] != 2'b00)
        begin
            nxt_pslverr = 1'b1;
        end
        else if (idx == phyirq_pkg::IDX_EN_LOW)
        begin
            nxt_prdata[7:0] = en_low_ff;
        end
        else if (idx == phyirq_pkg::IDX_EN_HIGH)
        begin
            nxt_prdata[7:0] = en_high_ff;
        end
        else if ((idx == phyirq_pkg::IDX_CLR_LOW) || (idx == phyirq_pkg::IDX_CLR_HIGH))
        begin
            // [R4] clear bits always read zero
            nxt_prdata = 32'h0000_0000;
        end
        else if (idx == phyirq_pkg::IDX_PIN_CTL)
        begin
            nxt_prdata[7:0] = ctl_ff;
        end
        else if (idx == phyirq_pkg::IDX_AN_LIMIT)
        begin
            nxt_prdata[7:0] = an_limit_ff;
        end
        else if (idx == phyirq_pkg::IDX_LINK_LIMIT)
        begin
            nxt_prdata[7:0] = link_limit_ff;
        end
        else if (idx == phyirq_pkg::IDX_ERR_LIMIT)
        begin
            nxt_prdata[7:0] = err_limit_ff;
        end
        else if (idx == phyirq_pkg::IDX_FLAGS_LOW)
        begin
            nxt_prdata[7:0] = flags_ff[7:0];
        end
        else if (idx == phyirq_pkg::IDX_FLAGS_HIGH)
        begin
            nxt_prdata[7:0] = flags_ff[15:8];
        end
        else if (idx == phyirq_pkg::IDX_AN_COUNT)
        begin
            nxt_prdata[7:0] = an_cnt_ff;
        end
        else if (idx == phyirq_pkg::IDX_ERR_COUNT)
        begin
            nxt_prdata[7:0] = err_cnt_ff;
        end
        else
        begin
            // unmapped word
            nxt_pslverr = 1'b1;
        end
    end

    // apb answer: one access cycle, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            pready_ff  <= 1'b1;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
        end
        else
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
    end

    // [R11] enabled flags only
    assign irq_active = (|(flags_ff & {en_high_ff, en_low_ff}))
                      && ctl_ff[phyirq_pkg::CTL_MODE] && led_enable;

    // pin drive with polarity; idle high after reset (active low)
    // [R7] gate and polarity
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_pin_ff <= 1'b1;
        end
        else
        begin
            irq_pin_ff <= ctl_ff[phyirq_pkg::CTL_POLARITY] ? irq_active : !irq_active;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq_pin = irq_pin_ff;

    // checks on the logic above
    an_clear_a : assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        (lo_wr && pwdata[7] && !evt.autoneg_done) |=> (an_cnt_ff == 8'h00) && !flags_ff[7])
        else $error("autoneg alarm clear failed");
    link_clear_a : assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        (lo_wr && pwdata[3]) |=> (l10_cnt_ff == 8'h00) && (l100_cnt_ff == 8'h00) && (l1000_cnt_ff == 8'h00))
        else $error("link counters not reset");
    flag_clear_a : assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        lo_wr |=> ((flags_ff[7:0] & $past(pwdata[7:0]) & ~$past(set_vec[7:0])) == 8'h00))
        else $error("low flag not cleared");
    zero_write_a : assert property (@(posedge pclk) disable iff (!presetn) // [R4]
        ((lo_wr || hi_wr) && (pwdata[7:0] == 8'h00)) |=> (flags_ff == ($past(flags_ff) | $past(set_vec))))
        else $error("zero clear write changed flags");
    high_inert_a : assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        (hi_wr && (pwdata[6:3] == 4'h0) && !pwdata[0]) |=> (flags_ff == ($past(flags_ff) | $past(set_vec))))
        else $error("inert high clear bit acted");
    err_clear_a : assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        (hi_wr && pwdata[3] && !err_hit) |=> !flags_ff[11])
        else $error("error alarm not cleared");
    pin_off_a : assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        (!ctl_ff[2] || !led_enable) |=> (irq_pin == !$past(ctl_ff[0])))
        else $error("disabled pin not idle");
    an_limit_a : assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        (wr_en && (paddr == {phyirq_pkg::IDX_AN_LIMIT, 2'b00})) |=> (an_limit_ff == $past(pwdata[7:0])))
        else $error("autoneg limit not stored");
    link_limit_a : assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        (wr_en && (paddr == {phyirq_pkg::IDX_LINK_LIMIT, 2'b00})) |=> (link_limit_ff == $past(pwdata[7:0])))
        else $error("link limit not stored");
    err_limit_a : assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        (wr_en && (paddr == {phyirq_pkg::IDX_ERR_LIMIT, 2'b00})) |=> (err_limit_ff == $past(pwdata[7:0])))
        else $error("error limit not stored");
    mask_gate_a : assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        ((flags_ff & {en_high_ff, en_low_ff}) == 16'h0000) |=> (irq_pin == !$past(ctl_ff[0])))
        else $error("masked flag reached pin");
    alarm_hold_a : assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (flags_ff[7] && !an_clr) |=> flags_ff[7])
        else $error("autoneg alarm dropped without clear");
    alarm_set_a : assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (evt.autoneg_done && !an_clr && (an_cnt_ff != 8'hff) && ((an_cnt_ff + 8'h01) == an_limit_ff)) |=> flags_ff[7])
        else $error("autoneg alarm not raised at limit");

endmodule // phyirq_top

// *** phyirq_pkg.sv ***
package phyirq_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_EN_LOW      = 16'h8113;
    localparam logic [15:0] IDX_EN_HIGH     = 16'h8114;
    localparam logic [15:0] IDX_CLR_LOW     = 16'h8115;
    localparam logic [15:0] IDX_CLR_HIGH    = 16'h8116;
    localparam logic [15:0] IDX_PIN_CTL     = 16'h8117;
    localparam logic [15:0] IDX_AN_LIMIT    = 16'h8118;
    localparam logic [15:0] IDX_LINK_LIMIT  = 16'h8119;
    localparam logic [15:0] IDX_ERR_LIMIT   = 16'h811a;
    localparam logic [15:0] IDX_FLAGS_LOW   = 16'h8120;
    localparam logic [15:0] IDX_FLAGS_HIGH  = 16'h8121;
    localparam logic [15:0] IDX_AN_COUNT    = 16'h8122;
    localparam logic [15:0] IDX_ERR_COUNT   = 16'h8123;

    // reset values
    localparam logic [7:0]  RST_LIMIT       = 8'hff;
    localparam logic [7:0]  RST_CTL         = 8'h00;
    localparam logic [7:0]  RST_EN          = 8'h00;

    // writable clear bits of the high clear register
    localparam logic [7:0]  CLR_HIGH_MASK   = 8'h79;
    // enable bits of the high enable register that exist
    localparam logic [7:0]  EN_HIGH_MASK    = 8'h7f;

    // flag positions in the 16-bit latched flag vector
    localparam int          FLG_AN_ALARM    = 7;
    localparam int          FLG_AN_DONE     = 6;
    localparam int          FLG_REM_FAULT   = 5;
    localparam int          FLG_SPEED       = 4;
    localparam int          FLG_LINK_ALARM  = 3;
    localparam int          FLG_LINK        = 2;
    localparam int          FLG_DUPLEX      = 1;
    localparam int          FLG_JABBER      = 0;
    localparam int          FLG_CONFIG      = 14;
    localparam int          FLG_LOC_RCVR    = 13;
    localparam int          FLG_REM_RCVR    = 12;
    localparam int          FLG_ERR_ALARM   = 11;
    localparam int          FLG_RESET       = 8;

    // pin control fields
    localparam int          CTL_MODE        = 2;
    localparam int          CTL_POLARITY    = 0;

    // one-cycle event strobes from the transceiver core
    typedef struct packed {
        logic autoneg_done;
        logic remote_fault;
        logic speed;
        logic link;
        logic duplex;
        logic jabber;
        logic config_chg;
        logic loc_rcvr;
        logic rem_rcvr;
        logic reset_evt;
        logic error;
        logic link10;
        logic link100;
        logic link1000;
    } phyirq_evt_type;

endpackage

// *** phyirq_host.sv ***
`timescale 1ns/10ps
// host side: apb master that reaches the interrupt registers
module phyirq_host
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [17:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // bus idle at time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 18'h00000;
        pwdata  = 32'h00000000;
    end

    // one transfer; request held until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic err);
        wait (presetn === 1'b1);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        // release; stale address and data are inverted so nothing leans on them
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~paddr;
        pwdata  <= ~pwdata;
    endtask
endmodule // phyirq_host

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
    // design and bus signals
    logic                       pclk;
    logic                       presetn;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [17:0]                paddr;
    logic [31:0]                pwdata;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    phyirq_pkg::phyirq_evt_type evt;
    logic                       led_enable;
    logic                       irq_pin;
    // bookkeeping
    int                         fail_count;
    int                         checks;
    int                         cyc;
    logic [7:0]                 rdv;
    logic                       errv;

    phyirq_top i_phyirq_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(evt), .led_enable(led_enable), .irq_pin(irq_pin));
    phyirq_host i_phyirq_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // free running clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            fail_count = fail_count + 1;
            close_out;
        end
    end

    // verdict and end of run
    task close_out;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one compare
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks = checks + 1;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            fail_count = fail_count + 1;
        end
    endtask

    // register read and compare, error flag must stay low
    task rchk(input string nm, input logic [15:0] idx, input logic [7:0] exp);
        i_phyirq_host.xfer(1'b0, idx, 8'h00, rdv, errv);
        chk(nm, exp, rdv);
        chk("pslverr", 8'h00, {7'h00, errv});
    endtask

    // register write
    task wr(input logic [15:0] idx, input logic [7:0] d);
        i_phyirq_host.xfer(1'b1, idx, d, rdv, errv);
    endtask

    // one-cycle event pulse on bit i of the event vector
    task pulse(input int i);
        @(posedge pclk);
        evt <= 14'h0001 << i;
        @(posedge pclk);
        evt <= 14'h0000;
    endtask

    // settle then compare the pin level
    task pchk(input logic exp);
        repeat (2) @(posedge pclk);
        #10;
        chk("irq_pin", {7'h00, exp}, {7'h00, irq_pin});
    endtask

    task t_reset;
        rchk("clr_low", phyirq_pkg::IDX_CLR_LOW, 8'h00);
        rchk("clr_high", phyirq_pkg::IDX_CLR_HIGH, 8'h00);
        rchk("pin_ctl", phyirq_pkg::IDX_PIN_CTL, 8'h00);
        rchk("an_limit", phyirq_pkg::IDX_AN_LIMIT, 8'hff);
        rchk("link_limit", phyirq_pkg::IDX_LINK_LIMIT, 8'hff);
        rchk("err_limit", phyirq_pkg::IDX_ERR_LIMIT, 8'hff);
        pchk(1'b1);
        i_phyirq_host.xfer(1'b0, 16'h8124, 8'h00, rdv, errv);
        chk("unmapped_err", 8'h01, {7'h00, errv});
        chk("unmapped_data", 8'h00, rdv);
    endtask

    // limits read back what was written
    task t_limits;
        for (int i = 0; i < 3; i++)
        begin
            wr(phyirq_pkg::IDX_AN_LIMIT + 16'(i), 8'h5a);
            rchk("limit_5a", phyirq_pkg::IDX_AN_LIMIT + 16'(i), 8'h5a);
            wr(phyirq_pkg::IDX_AN_LIMIT + 16'(i), 8'ha5);
            rchk("limit_a5", phyirq_pkg::IDX_AN_LIMIT + 16'(i), 8'ha5);
        end
    endtask

    // autoneg alarm at limit, clear zeroes counter
    task t_an;
        wr(phyirq_pkg::IDX_AN_LIMIT, 8'h03);
        pulse(13);
        pulse(13);
        rchk("an_below", phyirq_pkg::IDX_FLAGS_LOW, 8'h40);
        pulse(13);
        rchk("an_alarm", phyirq_pkg::IDX_FLAGS_LOW, 8'hc0);
        rchk("an_count", phyirq_pkg::IDX_AN_COUNT, 8'h03);
        wr(phyirq_pkg::IDX_CLR_LOW, 8'h40);
        rchk("an_stays", phyirq_pkg::IDX_FLAGS_LOW, 8'h80);
        wr(phyirq_pkg::IDX_CLR_LOW, 8'h80);
        rchk("an_cleared", phyirq_pkg::IDX_FLAGS_LOW, 8'h00);
        rchk("an_zeroed", phyirq_pkg::IDX_AN_COUNT, 8'h00);
    endtask

    // link alarm, clear restarts the 100 mb/s link counter
    task t_link;
        wr(phyirq_pkg::IDX_LINK_LIMIT, 8'h02);
        pulse(2);
        pulse(1);
        rchk("link_below", phyirq_pkg::IDX_FLAGS_LOW, 8'h00);
        pulse(2);
        rchk("link_alarm", phyirq_pkg::IDX_FLAGS_LOW, 8'h08);
        wr(phyirq_pkg::IDX_CLR_LOW, 8'h08);
        rchk("link_cleared", phyirq_pkg::IDX_FLAGS_LOW, 8'h00);
        pulse(1);
        rchk("link_restart", phyirq_pkg::IDX_FLAGS_LOW, 8'h00);
    endtask

    task t_err;
        wr(phyirq_pkg::IDX_ERR_LIMIT, 8'h02);
        pulse(3);
        rchk("err_below", phyirq_pkg::IDX_FLAGS_HIGH, 8'h00);
        pulse(3);
        rchk("err_alarm", phyirq_pkg::IDX_FLAGS_HIGH, 8'h08);
        rchk("err_count", phyirq_pkg::IDX_ERR_COUNT, 8'h02);
        wr(phyirq_pkg::IDX_CLR_HIGH, 8'h08);
        rchk("err_cleared", phyirq_pkg::IDX_FLAGS_HIGH, 8'h00);
    endtask

    // low flags, zero writes inert, clear bits self clear
    task automatic t_low;
        int lb[6] = '{0, 1, 2, 4, 5, 6};
        int le[6] = '{8, 9, 10, 11, 12, 13};
        for (int k = 0; k < 6; k++)
        begin
            pulse(le[k]);
            wr(phyirq_pkg::IDX_CLR_LOW, 8'h00);
            rchk("low_set", phyirq_pkg::IDX_FLAGS_LOW, 8'h01 << lb[k]);
            wr(phyirq_pkg::IDX_CLR_LOW, 8'h01 << lb[k]);
            rchk("low_clr", phyirq_pkg::IDX_FLAGS_LOW, 8'h00);
            rchk("clr_low_sc", phyirq_pkg::IDX_CLR_LOW, 8'h00);
        end
    endtask

    // high flags, bits 7 2 1 inert
    task automatic t_high;
        int hb[4] = '{6, 5, 4, 0};
        int he[4] = '{7, 6, 5, 4};
        for (int k = 0; k < 4; k++)
        begin
            pulse(he[k]);
            wr(phyirq_pkg::IDX_CLR_HIGH, 8'h86);
            rchk("high_set", phyirq_pkg::IDX_FLAGS_HIGH, 8'h01 << hb[k]);
            wr(phyirq_pkg::IDX_CLR_HIGH, 8'h01 << hb[k]);
            rchk("high_clr", phyirq_pkg::IDX_FLAGS_HIGH, 8'h00);
            rchk("clr_high_sc", phyirq_pkg::IDX_CLR_HIGH, 8'h00);
        end
    endtask

    // pin gate, polarity, led gate and source enable
    task automatic t_pin;
        logic [7:0] ctl[5] = '{8'h00, 8'h04, 8'h05, 8'h05, 8'h01};
        logic       led[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        logic       exp[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        wr(phyirq_pkg::IDX_EN_LOW, 8'h01);
        pulse(8);
        for (int k = 0; k < 5; k++)
        begin
            wr(phyirq_pkg::IDX_PIN_CTL, ctl[k]);
            @(posedge pclk);
            led_enable <= led[k];
            pchk(exp[k]);
        end
        @(posedge pclk);
        led_enable <= 1'b1;
        wr(phyirq_pkg::IDX_PIN_CTL, 8'h05);
        wr(phyirq_pkg::IDX_EN_LOW, 8'h00);
        pchk(1'b0);
        wr(phyirq_pkg::IDX_EN_LOW, 8'h01);
        pchk(1'b1);
        wr(phyirq_pkg::IDX_CLR_LOW, 8'h01);
        pchk(1'b0);
        // high byte source: reset event gated by its own enable
        pulse(4);
        pchk(1'b0);
        wr(phyirq_pkg::IDX_EN_HIGH, 8'h01);
        pchk(1'b1);
    endtask

    // reset then scenarios in turn
    initial
    begin
        presetn    = 1'b0;
        evt        = 14'h0000;
        led_enable = 1'b1;
        fail_count = 0;
        checks     = 0;
        cyc        = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_limits;
        t_an;
        t_link;
        t_err;
        t_low;
        t_high;
        t_pin;
        close_out;
    end
endmodule // tb
